// [hw/aiam_alarm_eval.sv]
// Module: one alarm comparator with disable, latch and momentary modes
`default_nettype none
module aiam_alarm_eval (
	input  wire logic   clk_i,     // System clock
	input  wire logic   reset_i,   // Synchronous reset
	aiam_alarm_if.eval  alm        // Alarm signals
);
	// ==========================================================
	// Condition
	logic cond;      // Over high limit or under low limit
	logic status_q;  // Alarm status
	logic status_d;  // Next status
	assign cond = alm.is_high ? (alm.value > alm.limit) : (alm.value < alm.limit);
	// Next status by mode
	always_comb begin
		status_d = status_q;
		case (alm.mode)
			aiam_pkg::AIAM_ALM_DISABLE:   status_d = 1'b0;
			aiam_pkg::AIAM_ALM_LATCH: begin
				// Set wins over clear; a persisting condition re-asserts
				if (alm.sample && cond) begin
					status_d = 1'b1;
				end else if (alm.clr_latch) begin
					status_d = 1'b0;
				end
			end
			aiam_pkg::AIAM_ALM_MOMENTARY: begin
				if (alm.sample) begin
					status_d = cond;
				end
			end
			default:                      status_d = 1'b0;
		endcase
	end
	// Status register
	always_ff @(posedge clk_i) begin
		if (reset_i) status_q <= 1'b0;
		else         status_q <= status_d;
	end
	assign alm.status = status_q;
endmodule : aiam_alarm_eval
`default_nettype wire

// [hw/aiam_alarm_if.sv]
// Interface: one alarm evaluator's configuration, sample and status
`default_nettype none
interface aiam_alarm_if;
	logic [15:0] value;        // Reported input value
	logic [15:0] limit;        // Alarm limit
	logic [1:0]  mode;         // Alarm mode
	logic        is_high;      // 1 high alarm, 0 low alarm
	logic        sample;       // New value valid this cycle
	logic        clr_latch;    // Clear latched status
	logic        status;       // Alarm status out
	modport eval (input value, limit, mode, is_high, sample, clr_latch, output status);
	modport ctrl (output value, limit, mode, is_high, sample, clr_latch, input status);
endinterface : aiam_alarm_if
`default_nettype wire

// [hw/aiam_monitor.sv]
// Module: top of the analog input alarm monitor with Wishbone register slave
//
// The Wishbone register port and the register addresses were chosen for this implementation.
`default_nettype none
// Function
// - Burnout only on current-loop range
// - Up-scale burnout forces value to FFFF
// - Down-scale burnout forces value to 0000
// - Alarm when above high or below low
// - Alarm sets status bit and indicator
// - Separate mode and limit per alarm
// - Disabled mode never asserts alarm
// - Latch holds alarm until clear command
// - Momentary status follows present condition
// - Running maximum, per-channel clear
// - Running minimum, per-channel clear
// - Permitted auto calibration runs twenty seconds
// - Two integration times, effective on apply
// - Average over host-selected channels
// - Range selection effective on apply
// - Locate lights indicator thirty seconds
module aiam_monitor #(
	parameter longint CAL_CYCLES    = aiam_pkg::CAL_CYCLES,    // Calibration length in cycles
	parameter longint LOCATE_CYCLES = aiam_pkg::LOCATE_CYCLES  // Locate length in cycles
) (
	input  wire logic        clk_i,          // System clock, 50 MHz
	input  wire logic        reset_i,        // Synchronous reset, active high
	input  wire logic        wb_cyc_i,       // Wishbone cycle
	input  wire logic        wb_stb_i,       // Wishbone strobe
	input  wire logic        wb_we_i,        // Wishbone write enable
	input  wire logic [8:0]  wb_adr_i,       // Wishbone byte address, nine bits reach all channels
	input  wire logic [3:0]  wb_sel_i,       // Wishbone byte selects
	input  wire logic [31:0] wb_dat_i,       // Wishbone write data
	output logic      [31:0] wb_dat_o,       // Wishbone read data
	output logic             wb_ack_o,       // Wishbone acknowledge
	input  wire logic [127:0] sample_i,      // Eight 16-bit conversions
	input  wire logic        sample_vld_i,   // Conversions valid pulse
	input  wire logic [7:0]  open_i,         // Open-circuit detect per channel
	output logic      [7:0]  alarm_led_o,    // Alarm indicator per channel
	output logic             status_led_o,   // Locate status indicator
	output logic             cal_run_o,      // Calibration in progress
	output logic      [7:0]  range_o [0:7],  // Active range per channel
	output logic      [7:0]  integ_o         // Active integration select per channel
);

	// ==========================================================
	// Storage
	logic [15:0] cfg_q    [0:7];   // Pending configuration per channel
	logic [15:0] lo_lim_q [0:7];   // Low limits
	logic [15:0] hi_lim_q [0:7];   // High limits
	logic [15:0] val_q    [0:7];   // Reported values
	logic [15:0] max_q    [0:7];   // Running maxima
	logic [15:0] min_q    [0:7];   // Running minima
	logic [2:0]  act_rng_q [0:7];  // Applied range
	logic [7:0]  act_int_q;        // Applied integration select
	logic [7:0]  avg_sel_q;        // Averaging mask
	logic [15:0] avg_q;            // Average result
	logic        upd_q;            // Values updated last cycle
	logic [7:0]  burn_q;           // Burnout active flags
	logic [7:0]  lo_stat;          // Low alarm statuses
	logic [7:0]  hi_stat;          // High alarm statuses
	logic        ack_q;            // Bus acknowledge
	logic [31:0] rdat_q;           // Read data
	logic        cal_allow_q;      // Calibration permitted
	logic        cal_done_q;       // Calibration finished, awaiting confirm
	logic [31:0] cal_cnt_q;        // Calibration timer
	logic [31:0] loc_cnt_q;        // Locate timer
	logic        loc_on_q;         // Locate indicator
	aiam_pkg::aiam_cal_state_t cal_st_q; // Calibration state

	// ==========================================================
	// Bus decode
	// Writes need both low byte lanes; narrower ones are acked and dropped
	wire        bus_req  = wb_cyc_i && wb_stb_i && !ack_q;           // New access, at most one every two cycles
	wire        bus_wr   = bus_req && wb_we_i && (wb_sel_i[1:0] == 2'h3);
	wire        glb_sel  = wb_adr_i[8:6] == 3'h0;                    // Global register area
	// Eight 32-byte blocks follow the globals; above them only ack answers
	wire        ch_sel   = !glb_sel && (wb_adr_i[8:5] < 4'ha);       // Per-channel area
	wire [2:0]  ch_idx   = 3'(wb_adr_i[8:5] - 4'h2);                 // Channel from address
	wire [4:0]  ch_ofs   = wb_adr_i[4:0];                            // Word within channel
	wire        wr_ctrl  = bus_wr && glb_sel && (wb_adr_i[7:0] == aiam_pkg::OFS_CTRL);
	wire        wr_avg   = bus_wr && glb_sel && (wb_adr_i[7:0] == aiam_pkg::OFS_AVG_SEL);
	wire        wr_clrmm = bus_wr && glb_sel && (wb_adr_i[7:0] == aiam_pkg::OFS_CLR_MAXMIN);
	wire        wr_clrl  = bus_wr && glb_sel && (wb_adr_i[7:0] == aiam_pkg::OFS_CLR_LATCH);
	wire        wr_cfg   = bus_wr && ch_sel && (ch_ofs == aiam_pkg::CH_CFG);
	wire        wr_lo    = bus_wr && ch_sel && (ch_ofs == aiam_pkg::CH_LO_LIM);
	wire        wr_hi    = bus_wr && ch_sel && (ch_ofs == aiam_pkg::CH_HI_LIM);
	wire        do_apply = wr_ctrl && wb_dat_i[aiam_pkg::CTRL_APPLY];
	wire        do_cstart = wr_ctrl && wb_dat_i[aiam_pkg::CTRL_CAL_START];
	wire        do_capply = wr_ctrl && wb_dat_i[aiam_pkg::CTRL_CAL_APPLY];
	wire        do_locate = wr_ctrl && wb_dat_i[aiam_pkg::CTRL_LOCATE];
	// Latch clears last for the write cycle only
	wire [7:0]  clr_latch = wr_clrl ? wb_dat_i[7:0] : 8'h00;

	// ==========================================================
	// Read mux
	// Decoded from the request cycle and registered with ack
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (glb_sel) begin
			case (wb_adr_i[7:0])
				aiam_pkg::OFS_CTRL:     rd_mux = {31'h0, cal_allow_q} << aiam_pkg::CTRL_CAL_ALLOW;
				aiam_pkg::OFS_STATUS:   rd_mux = {28'h0, |(lo_stat | hi_stat), loc_on_q, cal_done_q,
				                                  cal_st_q == aiam_pkg::AIAM_CAL_RUN};
				aiam_pkg::OFS_AVG_SEL:  rd_mux = {24'h0, avg_sel_q};
				aiam_pkg::OFS_AVG_VAL:  rd_mux = {16'h0, avg_q};
				aiam_pkg::OFS_ALM_STAT: rd_mux = {16'h0, hi_stat, lo_stat};
				default:                rd_mux = 32'h0000_0000;
			endcase
		end else if (ch_sel) begin
			case (ch_ofs)
				aiam_pkg::CH_CFG:    rd_mux = {16'h0, cfg_q[ch_idx]};
				aiam_pkg::CH_LO_LIM: rd_mux = {16'h0, lo_lim_q[ch_idx]};
				aiam_pkg::CH_HI_LIM: rd_mux = {16'h0, hi_lim_q[ch_idx]};
				aiam_pkg::CH_VALUE:  rd_mux = {16'h0, val_q[ch_idx]};
				aiam_pkg::CH_MAX:    rd_mux = {16'h0, max_q[ch_idx]};
				aiam_pkg::CH_MIN:    rd_mux = {16'h0, min_q[ch_idx]};
				aiam_pkg::CH_ACTIVE: rd_mux = {27'h0, burn_q[ch_idx], act_int_q[ch_idx], act_rng_q[ch_idx]};
				default:             rd_mux = 32'h0000_0000;
			endcase
		end
	end
	// Acknowledge every access one cycle after the request; unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q  <= bus_req;
			rdat_q <= rd_mux;
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// ==========================================================
	// Global control registers
	// Apply copies every channel at once, so settings switch together
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cal_allow_q <= 1'b0;
			avg_sel_q   <= 8'h00;
			act_int_q   <= 8'h00;
		end else begin
			if (wr_ctrl) cal_allow_q <= wb_dat_i[aiam_pkg::CTRL_CAL_ALLOW];
			if (wr_avg)  avg_sel_q   <= wb_dat_i[7:0];
			if (do_apply) begin
				for (int i = 0; i < 8; i++) act_int_q[i] <= cfg_q[i][aiam_pkg::CFG_INTEG];
			end
		end
	end

	// ==========================================================
	// Per-channel processing
	generate
		for (genvar c = 0; c < 8; c++) begin : g_ch
			wire [15:0] raw   = sample_i[c*16 +: 16];
			wire        mm_clr = wr_clrmm && wb_dat_i[c];   // Max/min clear for this channel
			// Burnout needs the applied range, not the pending one
			wire        burn  = open_i[c] && cfg_q[c][aiam_pkg::CFG_BURN_EN] &&
			                    (act_rng_q[c] == aiam_pkg::RANGE_4_20MA);
			wire [15:0] rep   = !burn ? raw :
			                    cfg_q[c][aiam_pkg::CFG_BURN_UP] ? aiam_pkg::BURN_UP_VAL
			                                                    : aiam_pkg::BURN_DN_VAL;
			// Configuration, limits, values, extremes
			always_ff @(posedge clk_i) begin
				if (reset_i) begin
					cfg_q[c]     <= aiam_pkg::CFG_RESET;
					lo_lim_q[c]  <= aiam_pkg::LO_LIM_RESET;
					hi_lim_q[c]  <= aiam_pkg::HI_LIM_RESET;
					act_rng_q[c] <= 3'h0;
					val_q[c]     <= 16'h0000;
					max_q[c]     <= 16'h0000;
					min_q[c]     <= 16'hffff;
					burn_q[c]    <= 1'b0;
				end else begin
					if (wr_cfg && ch_idx == 3'(c)) cfg_q[c]    <= wb_dat_i[15:0];
					if (wr_lo  && ch_idx == 3'(c)) lo_lim_q[c] <= wb_dat_i[15:0];
					if (wr_hi  && ch_idx == 3'(c)) hi_lim_q[c] <= wb_dat_i[15:0];
					if (do_apply) act_rng_q[c] <= cfg_q[c][2:0];
					// A clear arriving with a sample restarts from that sample, so no clear is lost
					if (sample_vld_i) begin
						val_q[c]  <= rep;
						burn_q[c] <= burn;
						if (mm_clr || rep > max_q[c]) max_q[c] <= rep;
						if (mm_clr || rep < min_q[c]) min_q[c] <= rep;
					end else if (mm_clr) begin
						// Cleared extremes start empty until the next conversion
						max_q[c]    <= 16'h0000;
						min_q[c]    <= 16'hffff;
					end
				end
			end
			// Low and high alarm evaluators
			// Both see the value one cycle after it was captured
			aiam_alarm_if lo_if ();
			aiam_alarm_if hi_if ();
			assign lo_if.value = val_q[c];
			assign lo_if.limit = lo_lim_q[c];
			assign lo_if.mode  = cfg_q[c][aiam_pkg::CFG_LO_MODE +: 2];
			assign lo_if.is_high = 1'b0;
			assign lo_if.sample = upd_q;
			assign lo_if.clr_latch = clr_latch[c];
			assign hi_if.value = val_q[c];
			assign hi_if.limit = hi_lim_q[c];
			assign hi_if.mode  = cfg_q[c][aiam_pkg::CFG_HI_MODE +: 2];
			assign hi_if.is_high = 1'b1;
			assign hi_if.sample = upd_q;
			assign hi_if.clr_latch = clr_latch[c];
			aiam_alarm_eval u_lo (.clk_i(clk_i), .reset_i(reset_i), .alm(lo_if));
			aiam_alarm_eval u_hi (.clk_i(clk_i), .reset_i(reset_i), .alm(hi_if));
			assign lo_stat[c] = lo_if.status;
			assign hi_stat[c] = hi_if.status;
			// Range code padded to the byte-wide port
			assign range_o[c] = {5'h00, act_rng_q[c]};
		end
	endgenerate

	// ==========================================================
	// Average over selected channels, and alarm indicators
	// Floor mean by a small divider; it only ever sees eight values
	logic [18:0] avg_sum;
	logic [3:0]  avg_n;
	always_comb begin
		avg_sum = 19'h0;
		avg_n   = 4'h0;
		for (int i = 0; i < 8; i++) begin
			if (avg_sel_q[i]) begin
				avg_sum = avg_sum + {3'h0, val_q[i]};
				avg_n   = avg_n + 4'h1;
			end
		end
	end
	// Update flag lines the evaluators up with the new values
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			upd_q       <= 1'b0;
			avg_q       <= 16'h0000;
			alarm_led_o <= 8'h00;
		end else begin
			upd_q       <= sample_vld_i;
			avg_q       <= (avg_n == 4'h0) ? 16'h0000 : 16'(avg_sum / {15'h0, avg_n});
			alarm_led_o <= lo_stat | hi_stat;
		end
	end
	assign integ_o = act_int_q;

	// ==========================================================
	// Auto calibration sequence
	// Start counts only when an earlier write permitted calibration
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cal_st_q   <= aiam_pkg::AIAM_CAL_IDLE;
			cal_cnt_q  <= 32'h0;
			cal_done_q <= 1'b0;
			cal_run_o  <= 1'b0;
		end else begin
			case (cal_st_q)
				aiam_pkg::AIAM_CAL_IDLE: begin
					if (do_cstart && cal_allow_q) begin
						cal_st_q  <= aiam_pkg::AIAM_CAL_RUN;
						cal_cnt_q <= 32'(CAL_CYCLES - 1);
						cal_run_o <= 1'b1;
					end
				end
				aiam_pkg::AIAM_CAL_RUN: begin
					if (cal_cnt_q == 32'h0) begin
						cal_st_q   <= aiam_pkg::AIAM_CAL_WAIT;
						cal_done_q <= 1'b1;
						cal_run_o  <= 1'b0;
					end else begin
						cal_cnt_q <= cal_cnt_q - 32'h1;
					end
				end
				aiam_pkg::AIAM_CAL_WAIT: begin
					// Results held until the host confirms them
					if (do_capply) begin
						cal_st_q   <= aiam_pkg::AIAM_CAL_IDLE;
						cal_done_q <= 1'b0;
					end
				end
				default: cal_st_q <= aiam_pkg::AIAM_CAL_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Locate indicator timer
	// A new locate request restarts the full on time
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			loc_on_q  <= 1'b0;
			loc_cnt_q <= 32'h0;
		end else if (do_locate) begin
			loc_on_q  <= 1'b1;
			loc_cnt_q <= 32'(LOCATE_CYCLES - 1);
		end else if (loc_on_q) begin
			if (loc_cnt_q == 32'h0) loc_on_q <= 1'b0;
			else                    loc_cnt_q <= loc_cnt_q - 32'h1;
		end
	end
	assign status_led_o = loc_on_q;
endmodule : aiam_monitor
`default_nettype wire

// [hw/aiam_pkg.sv]
// Package: register map, field layouts, modes and timing constants of the analog input alarm monitor
`default_nettype none
package aiam_pkg;
	// ==========================================================
	// Sizes
	localparam int          NUM_CH        = 8;               // Input channels
	localparam int          CH_W          = 3;               // Channel index width
	localparam int          DATA_W        = 16;              // Sample width
	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0]  OFS_CTRL      = 8'h00;           // Apply, cal, locate commands
	localparam logic [7:0]  OFS_STATUS    = 8'h04;           // Cal busy, locate on, alarm any
	localparam logic [7:0]  OFS_AVG_SEL   = 8'h08;           // Channel mask for averaging
	localparam logic [7:0]  OFS_AVG_VAL   = 8'h0c;           // Average of selected channels
	localparam logic [7:0]  OFS_ALM_STAT  = 8'h10;           // [7:0] low, [15:8] high status
	localparam logic [7:0]  OFS_CLR_MAXMIN = 8'h14;          // Write 1: clear max/min per channel
	localparam logic [7:0]  OFS_CLR_LATCH = 8'h18;           // Write 1: clear latch per channel
	localparam logic [7:0]  OFS_CH_BASE   = 8'h40;           // Per-channel block base
	localparam int          CH_STRIDE_SH  = 5;               // 32 bytes per channel
	// Per-channel word offsets within the block (byte offset)
	localparam logic [4:0]  CH_CFG        = 5'h00;           // Range, burnout, integ, modes
	localparam logic [4:0]  CH_LO_LIM     = 5'h04;           // Low alarm limit
	localparam logic [4:0]  CH_HI_LIM     = 5'h08;           // High alarm limit
	localparam logic [4:0]  CH_VALUE      = 5'h0c;           // Reported value
	localparam logic [4:0]  CH_MAX        = 5'h10;           // Running maximum
	localparam logic [4:0]  CH_MIN        = 5'h14;           // Running minimum
	localparam logic [4:0]  CH_ACTIVE     = 5'h18;           // Active range/integ, burnout flag
	// ==========================================================
	// Control bits
	localparam int          CTRL_APPLY    = 0;               // Apply pending range/integration
	localparam int          CTRL_CAL_ALLOW = 1;              // Calibration permitted (level)
	localparam int          CTRL_CAL_START = 2;              // Start auto calibration
	localparam int          CTRL_CAL_APPLY = 3;              // Confirm calibration
	localparam int          CTRL_LOCATE   = 4;               // Start locate indicator
	// Config field positions
	localparam int          CFG_RANGE_LSB = 0;               // 3-bit range code
	localparam int          CFG_BURN_EN   = 3;               // Burnout detection enable
	localparam int          CFG_BURN_UP   = 4;               // 1 up-scale, 0 down-scale
	localparam int          CFG_INTEG     = 5;               // Integration time select
	localparam int          CFG_LO_MODE   = 8;               // 2-bit low alarm mode
	localparam int          CFG_HI_MODE   = 10;              // 2-bit high alarm mode
	localparam logic [2:0]  RANGE_4_20MA  = 3'h7;            // Current-loop range code
	localparam logic [15:0] CFG_RESET     = 16'h0000;        // Config reset value
	localparam logic [15:0] LO_LIM_RESET  = 16'h0000;        // Low limit reset value
	localparam logic [15:0] HI_LIM_RESET  = 16'hffff;        // High limit reset value
	localparam logic [15:0] BURN_UP_VAL   = 16'hffff;        // Up-scale forced value
	localparam logic [15:0] BURN_DN_VAL   = 16'h0000;        // Down-scale forced value
	// ==========================================================
	// Alarm modes
	typedef enum logic [1:0] {
		AIAM_ALM_DISABLE   = 2'b00,
		AIAM_ALM_LATCH     = 2'b01,
		AIAM_ALM_MOMENTARY = 2'b10
	} aiam_alm_mode_t;
	// Calibration states
	typedef enum logic [1:0] {
		AIAM_CAL_IDLE = 2'b00,
		AIAM_CAL_RUN  = 2'b01,
		AIAM_CAL_WAIT = 2'b10
	} aiam_cal_state_t;
	// ==========================================================
	// Timing
	localparam longint      CLK_HZ        = 50000000;        // System clock rate
	localparam longint      CAL_TIME_S    = 20;              // Auto calibration duration
	localparam longint      LOCATE_TIME_S = 30;              // Locate indicator on time
	localparam longint      CAL_CYCLES    = CAL_TIME_S * CLK_HZ;
	localparam longint      LOCATE_CYCLES = LOCATE_TIME_S * CLK_HZ;
	localparam int          TMR_W         = 32;              // Timer width
endpackage : aiam_pkg
`default_nettype wire

// [test/aiam_monitor_asserts.sv]
// Checker: port-level assertions for the analog input alarm monitor
`default_nettype none
module aiam_monitor_asserts #(
	parameter longint CAL_CYCLES    = 10, // Calibration length in cycles
	parameter longint LOCATE_CYCLES = 20  // Locate length in cycles
) (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic [31:0] wb_dat_o,
	input  wire logic        wb_ack_o,
	input  wire logic        sample_vld_i,
	input  wire logic [7:0]  alarm_led_o,
	input  wire logic        status_led_o,
	input  wire logic        cal_run_o,
	input  wire logic [7:0]  integ_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Helper counters: cycles spent high, so long counts avoid repetition
	logic [31:0] cal_cnt_q;   // Calibration high cycles
	logic [31:0] loc_cnt_q;   // Locate high cycles
	always_ff @(posedge clk_i) begin
		cal_cnt_q <= (reset_i || !cal_run_o) ? 32'h0 : cal_cnt_q + 32'h1;
		loc_cnt_q <= (reset_i || !status_led_o) ? 32'h0 : loc_cnt_q + 32'h1;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// ==========================================================
	// Bus answer timing
	AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
		else $error("ack without request");
	AST_DAT_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
		else $error("read data upper half not zero");
	// Timed indicators, small slack for registered edges
	AST_CAL_MAX: assert property (cal_cnt_q <= CAL_CYCLES + 1)
		else $error("calibration too long");
	AST_CAL_MIN: assert property ($fell(cal_run_o) |-> cal_cnt_q + 2 >= CAL_CYCLES)
		else $error("calibration too short");
	AST_LOC_MAX: assert property (loc_cnt_q <= LOCATE_CYCLES + 1)
		else $error("locate too long");
	AST_LOC_MIN: assert property ($fell(status_led_o) |-> loc_cnt_q + 2 >= LOCATE_CYCLES)
		else $error("locate too short");
	// Alarm indicator only rises three edges after a conversion
	AST_ALM_RISE: assert property ((alarm_led_o & ~$past(alarm_led_o)) != 8'h0 |-> $past(sample_vld_i, 3))
		else $error("alarm rose without a sample");
	// Integration select moves only around a register write
	AST_INTEG_APPLY: assert property ($changed(integ_o) |-> wb_ack_o || $past(wb_ack_o))
		else $error("integration changed without apply");
	COV_CAL: cover property ($fell(cal_run_o));
	COV_ALM: cover property (alarm_led_o != 8'h0);
	COV_LOC: cover property ($fell(status_led_o));
endmodule : aiam_monitor_asserts
bind aiam_monitor aiam_monitor_asserts #(.CAL_CYCLES(CAL_CYCLES), .LOCATE_CYCLES(LOCATE_CYCLES)) chk_u (
	.clk_i, .reset_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .sample_vld_i,
	.alarm_led_o, .status_led_o, .cal_run_o, .integ_o);
`default_nettype wire

// [test/aiam_sensor_model.sv]
// Model: analog front end that hands conversions to the monitor
`default_nettype none
module aiam_sensor_model (
	input  wire logic         clk_i,        // System clock
	output logic      [127:0] sample_o,     // Eight conversions
	output logic              sample_vld_o, // One-cycle valid pulse
	output logic      [7:0]   open_o        // Open-circuit flags
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sample_o = 128'h0;
		sample_vld_o = 1'b0;
		open_o = 8'h0;
	end
	// One conversion; lines garbled afterwards so stale data is never trusted
	task automatic convert(input logic [127:0] v, input logic [7:0] op);
		@(posedge clk_i);
		sample_o <= v;
		open_o <= op;
		sample_vld_o <= 1'b1;
		@(posedge clk_i);
		sample_o <= ~v;
		open_o <= ~op;
		sample_vld_o <= 1'b0;
	endtask : convert
endmodule : aiam_sensor_model
`default_nettype wire

// [test/test_aiam_monitor.sv]
// Testbench: register-level tests of the analog input alarm monitor
`default_nettype none
module test_aiam_monitor;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0, reset_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, vld, ack, stled, cal;
	logic [7:0] opn, led, integ;
	logic [8:0] adr = 9'h000;      // Byte address
	logic [3:0] sel = 4'hf;        // Byte selects
	logic [31:0] dat = 32'h0, rdat;
	logic [127:0] smp_w, smp;      // Model lines, next conversion set
	logic [7:0] rng [0:7];
	int bad_count = 0, tests_run = 0, cycles = 0;
	always #10 clk_i = ~clk_i;
	aiam_monitor #(.CAL_CYCLES(10), .LOCATE_CYCLES(20)) dut_u (.clk_i(clk_i), .reset_i(reset_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .sample_i(smp_w), .sample_vld_i(vld), .open_i(opn),
		.alarm_led_o(led), .status_led_o(stled), .cal_run_o(cal), .range_o(rng), .integ_o(integ));
	aiam_sensor_model snd (.clk_i(clk_i), .sample_o(smp_w), .sample_vld_o(vld), .open_o(opn));
	// ==========================================================
	// Bus and compare tasks
	task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask : chk
	task automatic rd(input logic [8:0] a, input logic [31:0] e, input string n);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(n, e, q);
	endtask : rd
	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	// Conversion, then wait until status and indicator have settled
	task automatic conv(input logic [7:0] op);
		snd.convert(smp, op);
		repeat (4) @(posedge clk_i);
	endtask : conv
	task automatic results;
		$display("comparisons %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : results
	// Hang guard, well above the few hundred cycles the tests need
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			results();
		end
	end
	// ==========================================================
	// Test sequence
	initial begin
		smp = {8{16'h0400}};
		repeat (20) @(posedge clk_i);
		reset_i <= 1'b0;
		rd(8'h48, 32'hffff, "high limit reset");
		rd(8'h3c, 32'h0, "unmapped read");
		sel <= 4'hc;
		wr(8'h48, 32'h1234);
		sel <= 4'hf;
		rd(8'h48, 32'hffff, "partial write");
		wr(9'h128, 32'h0abc);
		rd(9'h128, 32'h0abc, "channel 7 high limit");
		$display("test registers done");
		wr(8'h40, 32'h800);
		wr(8'h48, 32'h1000);
		smp[15:0] = 16'h2000;
		conv(8'h0);
		chk("alarm led", 32'h1, {24'h0, led});
		rd(8'h10, 32'h0100, "high status set");
		smp[15:0] = 16'h0800;
		conv(8'h0);
		rd(8'h10, 32'h0, "momentary drop");
		rd(8'h50, 32'h2000, "maximum");
		rd(8'h54, 32'h0800, "minimum");
		wr(8'h14, 32'h1);
		rd(8'h50, 32'h0, "maximum cleared");
		rd(8'h54, 32'hffff, "minimum cleared");
		$display("test momentary done");
		wr(8'h60, 32'h100);
		wr(8'h64, 32'h100);
		smp[31:16] = 16'h0050;
		conv(8'h0);
		rd(8'h10, 32'h2, "low status set");
		smp[31:16] = 16'h0500;
		conv(8'h0);
		chk("latched led", 32'h2, {24'h0, led});
		rd(8'h10, 32'h2, "latched status");
		wr(8'h18, 32'h2);
		rd(8'h10, 32'h0, "latch cleared");
		smp[31:16] = 16'h0050;
		conv(8'h0);
		rd(8'h10, 32'h2, "latch re-set");
		smp[31:16] = 16'h0500;
		conv(8'h0);
		wr(8'h18, 32'h2);
		$display("test latch done");
		for (int m = 0; m < 4; m += 3) begin
			wr(8'h80, (m << 10) | (m << 8));
			wr(8'h84, 32'hffff);
			wr(8'h88, 32'h10);
			smp[47:32] = 16'h2000;
			conv(8'h0);
			rd(8'h10, 32'h0, "disabled status");
		end
		$display("test disable done");
		wr(8'ha0, 32'h3f);
		smp[63:48] = 16'h1234;
		conv(8'h08);
		rd(8'hac, 32'h1234, "value before apply");
		wr(8'h00, 32'h1);
		conv(8'h08);
		chk("range", 32'h7, {24'h0, rng[3]});
		chk("integration", 32'h08, {24'h0, integ});
		rd(8'hac, 32'hffff, "up-scale value");
		wr(8'ha0, 32'h2f);
		wr(8'h00, 32'h1);
		conv(8'h08);
		rd(8'hac, 32'h0, "down-scale value");
		wr(8'ha0, 32'h1e);
		wr(8'h00, 32'h1);
		conv(8'h08);
		rd(8'hac, 32'h1234, "voltage range open");
		$display("test burnout done");
		wr(8'h08, 32'h09);
		rd(8'h0c, 32'h0d1a, "average");
		$display("test average done");
		wr(8'h00, 32'h2);
		wr(8'h00, 32'h6);
		rd(8'h04, 32'h1, "calibration running");
		chk("cal run", 32'h1, {31'h0, cal});
		repeat (20) @(posedge clk_i);
		rd(8'h04, 32'h2, "calibration done");
		wr(8'h00, 32'ha);
		rd(8'h04, 32'h0, "calibration confirmed");
		$display("test calibration done");
		wr(8'h00, 32'h10);
		@(posedge clk_i);
		chk("locate on", 32'h1, {31'h0, stled});
		repeat (25) @(posedge clk_i);
		chk("locate off", 32'h0, {31'h0, stled});
		$display("test locate done");
		results();
	end
endmodule : test_aiam_monitor
`default_nettype wire
